/* design/irq_flag_regs.svh */
// register offsets, field positions, masks and reset values of the
// interrupt flag and edge control block; byte addresses on a 32-bit bus
`ifndef IRQ_FLAG_REGS_SVH
`define IRQ_FLAG_REGS_SVH

`define ADDR_CTRL_TWO 6'h00
`define ADDR_FLAG_ZERO 6'h04
`define ADDR_FLAG_ONE 6'h08
`define ADDR_FLAG_TWO 6'h0C
`define ADDR_IRQ_STATUS 6'h10
`define ADDR_IRQ_MASK 6'h14

`define CTRL_ALT_VEC_BIT 15
`define CTRL_DISABLE_BIT 14
`define CTRL_WR_MASK 16'h8007
`define CTRL_RESET 16'h0000

`define FLAG_ZERO_MASK 16'hBFEF
`define FLAG_ONE_MASK 16'hFA1F
`define FLAG_TWO_MASK 16'h0023
`define FLAG_RESET 16'h0000

`define EXT0_FLAG_BIT 0
`define EXT1_FLAG_BIT 4
`define EXT2_FLAG_BIT 13

`define IRQ_EV_WIDTH 4
`define IRQ_EV_PERIPH_BIT 3
`define IRQ_RESET 4'h0

`endif

/* design/irq_flag_pkg.sv */
// types shared by the interrupt flag and edge control block
// assumes the constants header is included by the users of this package
package irq_flag_pkg;
    typedef struct packed {
        logic [15:0] f2;
        logic [15:0] f1;
        logic [15:0] f0;
    } flag_regs_t;

    typedef struct packed {
        logic [31:0] dat;
        logic [3:0] sel;
        logic [5:0] adr;
        logic we;
        logic stb;
        logic cyc;
    } wb_req_t;
endpackage : irq_flag_pkg

/* design/interrupt_flag_and_edge_control.sv */
// interrupt control register, external edge select and flag registers
// assumes a classic wishbone master, one clock, sources pulse synchronously
`timescale 1ns/10ps
`include "irq_flag_regs.svh"

module interrupt_flag_and_edge_control
    import irq_flag_pkg::*;
#(
    parameter int EXT_COUNT = 3
)
(
    input wire logic clk,
    input wire logic rst,
    input wire wb_req_t wbReq,
    output logic [31:0] wbDatO,
    output logic wbAckO,
    input wire flag_regs_t flagSet,
    input wire logic [2:0] extPin,
    input wire logic irqDisableActive,
    output logic altVectorSelect,
    output flag_regs_t flagsOut,
    output logic irqOut
);

    if (EXT_COUNT != 3)
    begin : g_check
        $error("EXT_COUNT must be 3");
    end

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [15:0] ctrl_ff;
    logic disableSeen_ff;
    flag_regs_t flags_ff;
    flag_regs_t nxt_flags;
    logic [31:0] datO_ff;
    logic ack_ff;
    logic [`IRQ_EV_WIDTH-1:0] status_ff;
    logic [`IRQ_EV_WIDTH-1:0] mask_ff;
    logic irq_ff;
    logic altVec_ff;
    logic [2:0] extSync1_ff;
    logic [2:0] extSync2_ff;
    logic [2:0] extPrev_ff;
    logic [2:0] extDet;
    logic access;
    logic wrStrobe;
    logic [15:0] laneMask;
    flag_regs_t hwSet;
    logic [`IRQ_EV_WIDTH-1:0] events;

    assign access = wbReq.cyc && wbReq.stb && !ack_ff;
    assign wrStrobe = access && wbReq.we;
    assign laneMask = {{8{wbReq.sel[1]}}, {8{wbReq.sel[0]}}};

    // ------------------------------------------------------------
    // external input synchronisers and edge detection
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            extSync1_ff <= 3'h0;
            extSync2_ff <= 3'h0;
            extPrev_ff <= 3'h0;
        end
        else
        begin
            extSync1_ff <= extPin;
            extSync2_ff <= extSync1_ff;
            extPrev_ff <= extSync2_ff;
        end
    end

    for (genvar i = 0; i < 3; i++)
    begin : g_edge
        // polarity 1 picks the falling edge, 0 the rising edge
        assign extDet[i] = ctrl_ff[i] ?
            (extPrev_ff[i] && !extSync2_ff[i]) :
            (!extPrev_ff[i] && extSync2_ff[i]);
    end

    // ------------------------------------------------------------
    // flag registers
    // ------------------------------------------------------------
    always_comb
    begin
        hwSet = flagSet;
        hwSet.f0[`EXT0_FLAG_BIT] = flagSet.f0[`EXT0_FLAG_BIT] | extDet[0];
        hwSet.f1[`EXT1_FLAG_BIT] = flagSet.f1[`EXT1_FLAG_BIT] | extDet[1];
        hwSet.f1[`EXT2_FLAG_BIT] = flagSet.f1[`EXT2_FLAG_BIT] | extDet[2];
    end

    function automatic logic [15:0] flagNext(
        input logic [15:0] cur,
        input logic [15:0] set,
        input logic hit,
        input logic [15:0] impl,
        input logic [15:0] lanes,
        input logic [15:0] wdat
    );
        logic [15:0] v;
        v = hit ? ((cur & ~lanes) | (wdat & lanes)) : cur;
        flagNext = (v | set) & impl;
    endfunction : flagNext

    always_comb
    begin
        nxt_flags.f0 = flagNext(flags_ff.f0, hwSet.f0,
            wrStrobe && wbReq.adr == `ADDR_FLAG_ZERO, `FLAG_ZERO_MASK,
            laneMask, wbReq.dat[15:0]);
        nxt_flags.f1 = flagNext(flags_ff.f1, hwSet.f1,
            wrStrobe && wbReq.adr == `ADDR_FLAG_ONE, `FLAG_ONE_MASK,
            laneMask, wbReq.dat[15:0]);
        nxt_flags.f2 = flagNext(flags_ff.f2, hwSet.f2,
            wrStrobe && wbReq.adr == `ADDR_FLAG_TWO, `FLAG_TWO_MASK,
            laneMask, wbReq.dat[15:0]);
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            flags_ff <= {3{`FLAG_RESET}};
        else
            flags_ff <= nxt_flags;
    end

    // ------------------------------------------------------------
    // control register
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            ctrl_ff <= `CTRL_RESET;
            disableSeen_ff <= 1'b0;
            altVec_ff <= 1'b0;
        end
        else
        begin
            if (wrStrobe && wbReq.adr == `ADDR_CTRL_TWO)
                ctrl_ff <= (ctrl_ff & ~(laneMask & `CTRL_WR_MASK)) |
                    (wbReq.dat[15:0] & laneMask & `CTRL_WR_MASK);
            disableSeen_ff <= irqDisableActive;
            altVec_ff <= ctrl_ff[`CTRL_ALT_VEC_BIT];
        end
    end

    // ------------------------------------------------------------
    // interrupt status, mask and output
    // ------------------------------------------------------------
    assign events = {|(hwSet.f0 | hwSet.f1 | hwSet.f2), extDet};

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            status_ff <= `IRQ_RESET;
            mask_ff <= `IRQ_RESET;
            irq_ff <= 1'b0;
        end
        else
        begin
            // a new event wins over a write-one-to-clear
            if (wrStrobe && wbReq.adr == `ADDR_IRQ_STATUS && wbReq.sel[0])
                status_ff <= (status_ff & ~wbReq.dat[`IRQ_EV_WIDTH-1:0]) |
                    events;
            else
                status_ff <= status_ff | events;
            if (wrStrobe && wbReq.adr == `ADDR_IRQ_MASK && wbReq.sel[0])
                mask_ff <= wbReq.dat[`IRQ_EV_WIDTH-1:0];
            irq_ff <= |(status_ff & mask_ff);
        end
    end

    // ------------------------------------------------------------
    // wishbone slave: answers one cycle after the request
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            ack_ff <= 1'b0;
            datO_ff <= 32'h0000_0000;
        end
        else
        begin
            ack_ff <= access;
            if (access)
            begin
                unique case (wbReq.adr)
                    `ADDR_CTRL_TWO:
                        datO_ff <= {16'h0000, ctrl_ff[`CTRL_ALT_VEC_BIT],
                            disableSeen_ff, 11'h000, ctrl_ff[2:0]};
                    `ADDR_FLAG_ZERO:
                        datO_ff <= {16'h0000, flags_ff.f0};
                    `ADDR_FLAG_ONE:
                        datO_ff <= {16'h0000, flags_ff.f1};
                    `ADDR_FLAG_TWO:
                        datO_ff <= {16'h0000, flags_ff.f2};
                    `ADDR_IRQ_STATUS:
                        datO_ff <= {28'h0000000, status_ff};
                    `ADDR_IRQ_MASK:
                        datO_ff <= {28'h0000000, mask_ff};
                    default:
                        datO_ff <= 32'h0000_0000;
                endcase
            end
        end
    end

    assign wbDatO = datO_ff;
    assign wbAckO = ack_ff;
    assign altVectorSelect = altVec_ff;
    assign flagsOut = flags_ff;
    assign irqOut = irq_ff;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    a_alt_vector_follows: assert property (
        @(posedge clk) disable iff (rst)
        ##1 altVec_ff == $past(ctrl_ff[`CTRL_ALT_VEC_BIT]))
        else $error("alternate vector select does not follow control");

    a_disable_status: assert property (
        @(posedge clk) disable iff (rst)
        disableSeen_ff == $past(irqDisableActive))
        else $error("disable status not shown");

    a_ctrl_unimpl_zero: assert property (
        @(posedge clk) disable iff (rst)
        (access && wbReq.adr == `ADDR_CTRL_TWO)
        |=> wbDatO[13:3] == 11'h000)
        else $error("control unimplemented bits read nonzero");

    a_fall_edge_flag: assert property (
        @(posedge clk) disable iff (rst)
        (ctrl_ff[1] && extPrev_ff[1] && !extSync2_ff[1])
        |=> flagsOut.f1[`EXT1_FLAG_BIT])
        else $error("falling edge did not set its flag");

    a_rise_edge_ignored: assert property (
        @(posedge clk) disable iff (rst)
        (ctrl_ff[0] && !extPrev_ff[0] && extSync2_ff[0]
            && !flags_ff.f0[`EXT0_FLAG_BIT]
            && !flagSet.f0[`EXT0_FLAG_BIT]
            && !(wrStrobe && wbReq.adr == `ADDR_FLAG_ZERO))
        |=> !flagsOut.f0[`EXT0_FLAG_BIT])
        else $error("rising edge taken on falling polarity");

    a_hw_set_flag: assert property (
        @(posedge clk) disable iff (rst)
        flagSet.f2[5] |=> flagsOut.f2[5])
        else $error("hardware set lost");

    a_flag_zero_layout: assert property (
        @(posedge clk) disable iff (rst)
        flagsOut.f0[14] == 1'b0 && flagsOut.f0[4] == 1'b0)
        else $error("flag reg zero reserved bit set");

    a_flag_one_layout: assert property (
        @(posedge clk) disable iff (rst)
        flagsOut.f1[10] == 1'b0 && flagsOut.f1[8:5] == 4'h0)
        else $error("flag reg one reserved bit set");

    a_flag_two_layout: assert property (
        @(posedge clk) disable iff (rst)
        flagsOut.f2[15:6] == 10'h000 && flagsOut.f2[4:2] == 3'h0)
        else $error("flag reg two reserved bit set");

    a_ext_edge_flag: assert property (
        @(posedge clk) disable iff (rst)
        extDet[2] |=> flagsOut.f1[`EXT2_FLAG_BIT])
        else $error("external edge did not set flag");

    a_flag_sticky: assert property (
        @(posedge clk) disable iff (rst)
        (flagsOut.f0[1] && !(wrStrobe && wbReq.adr == `ADDR_FLAG_ZERO))
        |=> flagsOut.f0[1])
        else $error("flag dropped without a write");

    a_set_beats_clear: assert property (
        @(posedge clk) disable iff (rst)
        (flagSet.f2[5] && wrStrobe && wbReq.adr == `ADDR_FLAG_TWO)
        |=> flagsOut.f2[5])
        else $error("software clear beat a hardware set");

    a_sync_two_stage: assert property (
        @(posedge clk) disable iff (rst)
        (!$past(rst) && !$past(rst, 2))
        |-> extSync2_ff == $past(extPin, 2))
        else $error("external input not taken through two stages");

    a_ctrl_write_mask: assert property (
        @(posedge clk) disable iff (rst)
        (wrStrobe && wbReq.adr == `ADDR_CTRL_TWO)
        |=> ctrl_ff[14:3] == 12'h000)
        else $error("write reached an unimplemented control bit");

    a_ack_one_cycle: assert property (
        @(posedge clk) disable iff (rst)
        wbAckO |=> !wbAckO)
        else $error("acknowledge held longer than one cycle");

    a_irq_level: assert property (
        @(posedge clk) disable iff (rst)
        irqOut == $past(|(status_ff & mask_ff)))
        else $error("interrupt output does not follow status and mask");

endmodule : interrupt_flag_and_edge_control

/* test/core_source_model.sv */
// model of the core and the peripheral interrupt sources
// assumes the bench calls its tasks; one clock, changes just after an edge
`timescale 1ns/10ps

module core_source_model
    import irq_flag_pkg::*;
(
    input wire logic clk,
    output flag_regs_t flagSet,
    output logic [2:0] extPin,
    output logic irqDisableActive
);
    initial
    begin
        flagSet = '0;
        extPin = 3'h0;
        irqDisableActive = 1'b0;
    end

    // --------------------------------------------------------------
    // source requests
    // --------------------------------------------------------------
    // one-cycle request pulse from the peripherals
    task automatic pulse(input flag_regs_t v);
        @(posedge clk);
        flagSet <= v;
        @(posedge clk);
        flagSet <= '0;
    endtask : pulse

    // pin levels and the core's disable state
    task automatic drive(input logic [2:0] p, input logic d);
        @(posedge clk);
        extPin <= p;
        irqDisableActive <= d;
    endtask : drive
endmodule : core_source_model

/* test/interrupt_flag_and_edge_control_tb_top.sv */
// self-checking bench for the interrupt flag and edge control block
// assumes the package, the constants header and the source model
`timescale 1ns/10ps
`include "irq_flag_regs.svh"

module interrupt_flag_and_edge_control_tb_top
    import irq_flag_pkg::*;
;
    logic clk = 1'b0;
    logic rst = 1'b1;
    wb_req_t wbReq = '0;
    logic [31:0] wbDatO;
    logic wbAckO;
    flag_regs_t flagSet;
    logic [2:0] extPin;
    logic irqDisableActive;
    logic altVectorSelect;
    flag_regs_t flagsOut;
    logic irqOut;
    int n_errors = 0;
    int check_count = 0;
    int cycles = 0;
    int seed = 33;
    logic [31:0] rd;
    flag_regs_t v;
    logic [15:0] impl [3] = '{16'hBFEF, 16'hFA1F, 16'h0023};
    logic [5:0] fadr [3] = '{`ADDR_FLAG_ZERO, `ADDR_FLAG_ONE, `ADDR_FLAG_TWO};
    int er [3] = '{0, 1, 1};
    logic [15:0] eb [3] = '{16'h0001, 16'h0010, 16'h2000};

    always #2 clk = ~clk;

    interrupt_flag_and_edge_control #(.EXT_COUNT(3)) DUT (
        .clk(clk), .rst(rst), .wbReq(wbReq), .wbDatO(wbDatO),
        .wbAckO(wbAckO), .flagSet(flagSet), .extPin(extPin),
        .irqDisableActive(irqDisableActive),
        .altVectorSelect(altVectorSelect), .flagsOut(flagsOut),
        .irqOut(irqOut));

    core_source_model PM (.clk(clk), .flagSet(flagSet), .extPin(extPin),
        .irqDisableActive(irqDisableActive));

    // --------------------------------------------------------------
    // helpers
    // --------------------------------------------------------------
    task automatic stop_test();
        $display("errors %0d checks %0d", n_errors, check_count);
        if (n_errors == 0 && check_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : stop_test

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp)
        begin
            n_errors++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // classic single cycle, held until ack is sampled high
    task automatic wb(input logic w, input logic [5:0] a, input logic [15:0] d);
        @(posedge clk);
        wbReq <= '{dat: {16'h0000, d}, sel: 4'hF, adr: a, we: w,
                   stb: 1'b1, cyc: 1'b1};
        do
        begin
            @(posedge clk);
        end
        while (wbAckO !== 1'b1);
        rd = wbDatO;
        wbReq <= '0;
    endtask : wb

    task automatic rchk(input logic [5:0] a, input logic [15:0] e);
        wb(1'b0, a, 16'h0000);
        chk(rd, {16'h0000, e});
    endtask : rchk

    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            n_errors++;
            stop_test();
        end
    end

    // --------------------------------------------------------------
    // scenarios
    // --------------------------------------------------------------
    initial
    begin
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        // all places after reset, the last one unmapped
        for (int a = 0; a < 7; a++)
            rchk(6'(a * 4), 16'h0000);
        wb(1'b1, `ADDR_CTRL_TWO, 16'hFFFF);
        rchk(`ADDR_CTRL_TWO, 16'h8007);
        chk(altVectorSelect, 1'b1);
        PM.drive(3'h0, 1'b1);
        rchk(`ADDR_CTRL_TWO, 16'hC007);
        wb(1'b1, `ADDR_CTRL_TWO, 16'h0000);
        PM.drive(3'h0, 1'b0);
        rchk(`ADDR_CTRL_TWO, 16'h0000);
        chk(altVectorSelect, 1'b0);
        for (int r = 0; r < 3; r++)
        begin
            wb(1'b1, fadr[r], 16'hFFFF);
            rchk(fadr[r], impl[r]);
            wb(1'b1, fadr[r], 16'h0000);
            rchk(fadr[r], 16'h0000);
        end
        repeat (4)
        begin
            v = 48'({$random(seed), $random(seed)});
            PM.pulse(v);
            for (int r = 0; r < 3; r++)
            begin
                rchk(fadr[r], v[r*16 +: 16] & impl[r]);
                chk({16'h0000, flagsOut[r*16 +: 16]},
                    {16'h0000, v[r*16 +: 16] & impl[r]});
                wb(1'b1, fadr[r], 16'h0000);
            end
        end
        // hardware set and software clear at the same edge
        fork
            wb(1'b1, `ADDR_FLAG_TWO, 16'h0000);
            PM.pulse('{16'h0020, 16'h0000, 16'h0000});
        join
        rchk(`ADDR_FLAG_TWO, 16'h0020);
        wb(1'b1, `ADDR_FLAG_TWO, 16'h0000);
        // each pin with each polarity: active edge sets, other edge not
        for (int i = 0; i < 3; i++)
            for (int p = 0; p < 2; p++)
            begin
                wb(1'b1, `ADDR_CTRL_TWO, 16'(p << i));
                PM.drive(3'(p << i), 1'b0);
                repeat (6) @(posedge clk);
                wb(1'b1, fadr[er[i]], 16'h0000);
                PM.drive(3'((1 - p) << i), 1'b0);
                repeat (6) @(posedge clk);
                rchk(fadr[er[i]], eb[i]);
                wb(1'b1, fadr[er[i]], 16'h0000);
                PM.drive(3'(p << i), 1'b0);
                repeat (6) @(posedge clk);
                rchk(fadr[er[i]], 16'h0000);
            end
        // interrupt status, mask and level output
        rchk(`ADDR_IRQ_STATUS, 16'h000F);
        wb(1'b1, `ADDR_IRQ_STATUS, 16'h000F);
        rchk(`ADDR_IRQ_STATUS, 16'h0000);
        wb(1'b1, `ADDR_IRQ_MASK, 16'h0008);
        chk(irqOut, 1'b0);
        PM.pulse('{16'h0000, 16'h0008, 16'h0000});
        rchk(`ADDR_IRQ_STATUS, 16'h0008);
        chk(irqOut, 1'b1);
        wb(1'b1, `ADDR_IRQ_MASK, 16'h0000);
        @(posedge clk);
        chk(irqOut, 1'b0);
        wb(1'b1, `ADDR_IRQ_MASK, 16'h0008);
        @(posedge clk);
        chk(irqOut, 1'b1);
        wb(1'b1, `ADDR_IRQ_STATUS, 16'h0008);
        @(posedge clk);
        chk(irqOut, 1'b0);
        stop_test();
    end
endmodule : interrupt_flag_and_edge_control_tb_top
